// [tcfg_capture.sv]
// Tie-off configuration capture with Wishbone register port and
// gated observation outputs for an external logic analyzer.
// Assumes tie-offs are static from reset release until first run; power-domain run level is on clk_sys.
//
// Functional notes
// - Sample every tie-off after reset until the power domain first reaches run.
// - Output size code decodes to 32,36,40,42,44,48,52 bits.
// - Reserved size code is not driven; if seen it decodes as 52 bits.
// - Secure override high lets non-secure accesses reach secure-only registers.
// - Programmed message address equal to tie-off selects streaming delivery; here only once the capture has locked.
// - Stream identifier tie-off forms the device identifier of own messages.
// - Atomic tie-off enables hardware table updates; without it none are issued.
// - Identification table update field reads 00 without atomics, 10 with.
// - With analyzer build option 0 the analyzer enable is ignored.
// - With build option 1 the analyzer enable gates observation logic.
// - Analyzer enable is asynchronous and is synchronised before use.
// - Each observation group drives 128-bit word, 4-bit qualifier, 1-bit enable.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tcfg_defs.svh"
`default_nettype none

module tcfg_capture
#(
	parameter int NUM_GROUPS = 12,
	parameter bit ANALYZER_BUILD_OPTION = 1'b1
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic powerDomainLpiRun,
	input wire logic supCoherent,
	input wire logic supBroadcastMaint,
	input wire logic supSendEvent,
	input wire logic [2:0] supOutAddrSize,
	input wire logic secOverride,
	input wire tcfg_pkg::tcfg_qual_t engRevision,
	input wire tcfg_pkg::tcfg_addr_t msgAddrTie,
	input wire tcfg_pkg::tcfg_word_t streamIdTie,
	input wire logic supAtomic,
	input wire logic analyzerEnable,
	input wire logic [NUM_GROUPS*128-1:0] obsWordIn,
	input wire logic [NUM_GROUPS*4-1:0] obsQualIn,
	output logic [NUM_GROUPS*128-1:0] observation_word,
	output logic [NUM_GROUPS*4-1:0] observation_qualifier,
	output logic [NUM_GROUPS-1:0] observation_clk_enable,
	output logic configLocked,
	output logic coherentWalk,
	output logic broadcastMaintEn,
	output logic sendEventAvail,
	output logic nonsecureOverride,
	output tcfg_pkg::tcfg_bits_t outputAddrBits,
	output logic tableUpdateEnable,
	output logic [1:0] id0_table_update_field,
	output tcfg_pkg::tcfg_word_t msgDeviceId,
	output logic deliverOnStream,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire tcfg_pkg::tcfg_word_t wb_dat_i,
	output tcfg_pkg::tcfg_word_t wb_dat_o,
	output logic wb_ack_o
);
	import tcfg_pkg::*;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (NUM_GROUPS < 1 || NUM_GROUPS > 32)
	begin : g_bad_groups
		$error("NUM_GROUPS must lie between 1 and 32");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed
	{
		tcfg_state_t fsm;
		logic coh;
		logic btm;
		logic sev;
		logic sec;
		logic httu;
		logic [2:0] oas;
		tcfg_qual_t rev;
		tcfg_addr_t msiTie;
		tcfg_word_t sid;
		tcfg_word_t irqLo;
		logic [19:0] irqHi;
		logic ack;
		tcfg_word_t rdata;
		logic [NUM_GROUPS-1:0] obsEn;
		logic [NUM_GROUPS*128-1:0] obsWord;
		logic [NUM_GROUPS*4-1:0] obsQual;
	} tcfg_cap_state_t;

	tcfg_cap_state_t st_reg;
	tcfg_cap_state_t st_next;

	logic anaSync;
	logic obsActive;
	tcfg_bits_t bitsDecoded;
	logic [1:0] id0Field;
	logic addrMatch;
	logic wbReq;
	tcfg_word_t statusWord;
	logic [NUM_GROUPS*128-1:0] obsWordNext;
	logic [NUM_GROUPS*4-1:0] obsQualNext;

	// ------------------------------------------------------------
	// Analyzer enable synchroniser
	// ------------------------------------------------------------
	tcfg_sync u_ana_sync
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.asyncIn(analyzerEnable),
		.syncOut(anaSync)
	);

	// Build option 0 keeps the observation path always clocked
	assign obsActive = ANALYZER_BUILD_OPTION ? anaSync : 1'b1;

	// ------------------------------------------------------------
	// Observation groups
	// ------------------------------------------------------------
	// Held groups keep their last word: gating off freezes, never zeroes
	for (genvar g = 0; g < NUM_GROUPS; g++)
	begin : g_obs
		assign obsWordNext[g*128 +: 128] = obsActive ? obsWordIn[g*128 +: 128] : st_reg.obsWord[g*128 +: 128];
		assign obsQualNext[g*4 +: 4] = obsActive ? obsQualIn[g*4 +: 4] : st_reg.obsQual[g*4 +: 4];
	end

	// ------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------
	// Output address size, reserved code folds onto the widest size
	always_comb
	begin
		case (st_reg.oas)
			`TCFG_OAS_32: bitsDecoded = `TCFG_BITS_32;
			`TCFG_OAS_36: bitsDecoded = `TCFG_BITS_36;
			`TCFG_OAS_40: bitsDecoded = `TCFG_BITS_40;
			`TCFG_OAS_42: bitsDecoded = `TCFG_BITS_42;
			`TCFG_OAS_44: bitsDecoded = `TCFG_BITS_44;
			`TCFG_OAS_48: bitsDecoded = `TCFG_BITS_48;
			`TCFG_OAS_52: bitsDecoded = `TCFG_BITS_52;
			default: bitsDecoded = `TCFG_BITS_52;
		endcase
	end

	// Capability field and message address comparison
	assign id0Field = st_reg.httu ? `TCFG_ID0_ATOMIC : `TCFG_ID0_NONE;
	assign addrMatch = {st_reg.irqHi, st_reg.irqLo} == st_reg.msiTie;

	// Status word seen by software
	always_comb
	begin
		statusWord = `TCFG_RST_WORD;
		statusWord[`TCFG_ST_LOCKED_BIT] = (st_reg.fsm == TCFG_LOCKED);
		statusWord[`TCFG_ST_COH_BIT] = st_reg.coh;
		statusWord[`TCFG_ST_BTM_BIT] = st_reg.btm;
		statusWord[`TCFG_ST_SEV_BIT] = st_reg.sev;
		statusWord[`TCFG_ST_SEC_BIT] = st_reg.sec;
		statusWord[`TCFG_ST_HTTU_BIT] = st_reg.httu;
		statusWord[`TCFG_ST_ID0_LSB +: 2] = id0Field;
		statusWord[`TCFG_ST_OAS_LSB +: 3] = st_reg.oas;
		statusWord[`TCFG_ST_BITS_LSB +: 6] = bitsDecoded;
		statusWord[`TCFG_ST_OBS_BIT] = obsActive;
		statusWord[`TCFG_ST_REV_LSB +: 4] = st_reg.rev;
	end

	assign wbReq = wb_cyc_i && wb_stb_i && !st_reg.ack;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.ack = wbReq;
		st_next.obsEn = {NUM_GROUPS{obsActive}};
		st_next.obsWord = obsWordNext;
		st_next.obsQual = obsQualNext;

		// Capture sequencer: track tie-offs until first run entry
		case (st_reg.fsm)
			TCFG_SAMPLE:
			begin
				st_next.coh = supCoherent;
				st_next.btm = supBroadcastMaint;
				st_next.sev = supSendEvent;
				st_next.sec = secOverride;
				st_next.httu = supAtomic;
				st_next.oas = supOutAddrSize;
				st_next.rev = engRevision;
				st_next.msiTie = msgAddrTie;
				st_next.sid = streamIdTie;
				if (powerDomainLpiRun)
				begin
					st_next.fsm = TCFG_LOCKED;
				end
			end
			TCFG_LOCKED:
			begin
				st_next.fsm = TCFG_LOCKED;
			end
			default:
			begin
				st_next.fsm = TCFG_SAMPLE;
			end
		endcase

		// Wishbone writes honour byte lanes, unmapped offsets drop the data
		if (wbReq && wb_we_i)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (wb_sel_i[b] && wb_adr_i == `TCFG_ADR_IRQ_LO)
				begin
					st_next.irqLo[b*8 +: 8] = wb_dat_i[b*8 +: 8];
				end
			end
			for (int b = 0; b < 3; b++)
			begin
				if (wb_sel_i[b] && wb_adr_i == `TCFG_ADR_IRQ_HI)
				begin
					if (b == 2)
					begin
						st_next.irqHi[19:16] = wb_dat_i[19:16];
					end
					else
					begin
						st_next.irqHi[b*8 +: 8] = wb_dat_i[b*8 +: 8];
					end
				end
			end
		end

		// Read data, unmapped offsets read zero
		st_next.rdata = `TCFG_RST_WORD;
		if (wbReq && !wb_we_i)
		begin
			case (wb_adr_i)
				`TCFG_ADR_STATUS: st_next.rdata = statusWord;
				`TCFG_ADR_IRQ_LO: st_next.rdata = st_reg.irqLo;
				`TCFG_ADR_IRQ_HI: st_next.rdata = {12'h000, st_reg.irqHi};
				`TCFG_ADR_DEVID: st_next.rdata = st_reg.sid;
				`TCFG_ADR_MATCH: st_next.rdata = {31'h0000_0000, addrMatch};
				default: st_next.rdata = `TCFG_RST_WORD;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.fsm <= TCFG_SAMPLE;
			st_reg.irqHi <= `TCFG_RST_IRQ_HI;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign configLocked = (st_reg.fsm == TCFG_LOCKED);
	assign coherentWalk = st_reg.coh;
	assign broadcastMaintEn = st_reg.btm;
	assign sendEventAvail = st_reg.sev;
	assign nonsecureOverride = st_reg.sec;
	assign outputAddrBits = bitsDecoded;
	assign tableUpdateEnable = st_reg.httu;
	assign id0_table_update_field = id0Field;
	assign msgDeviceId = st_reg.sid;
	// Match only trusted once the tie-off is frozen
	assign deliverOnStream = configLocked && addrMatch;
	assign observation_word = st_reg.obsWord;
	assign observation_qualifier = st_reg.obsQual;
	assign observation_clk_enable = st_reg.obsEn;
	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	// Sampled reset: the release edge still loads reset state, so checks start one edge later
	default disable iff ($sampled(sys_rst));

	sequence s_run_seen;
		!configLocked && powerDomainLpiRun;
	endsequence

	sequence s_irq_write;
		wbReq && wb_we_i && (wb_adr_i == `TCFG_ADR_IRQ_LO) && (wb_sel_i == 4'hf);
	endsequence

	// Low word write that completes an address equal to the frozen tie-off
	sequence s_irq_hit;
		s_irq_write ##0 ({st_reg.irqHi, wb_dat_i} == st_reg.msiTie);
	endsequence

	a_lock_on_run: assert property (s_run_seen |=> configLocked && msgDeviceId == $past(streamIdTie))
		else $error("capture did not lock on first run entry");

	a_lock_stays: assert property (configLocked |=> configLocked && $stable(msgDeviceId) && $stable(outputAddrBits))
		else $error("captured configuration changed after lock");

	a_oas_decode: assert property (!configLocked && supOutAddrSize == `TCFG_OAS_42 |=> outputAddrBits == `TCFG_BITS_42)
		else $error("output size decode wrong");

	a_oas_reserved: assert property (!configLocked && supOutAddrSize == 3'h7 |=> outputAddrBits == `TCFG_BITS_52)
		else $error("reserved size code not folded to widest");

	a_id0_field: assert property (id0_table_update_field == (tableUpdateEnable ? 2'h2 : 2'h0))
		else $error("table update field mismatch");

	a_atomic_track: assert property (!configLocked && supAtomic |=> tableUpdateEnable)
		else $error("atomic support not reflected");

	a_stream_match: assert property (configLocked ##0 s_irq_hit |=> deliverOnStream)
		else $error("matching message address not routed to stream");

	a_obs_hold: assert property (!obsActive |=> $stable(observation_word) && !observation_clk_enable[0])
		else $error("observation moved while gated");

	a_obs_follow: assert property (obsActive |=> observation_word == $past(obsWordIn))
		else $error("observation did not follow source");

	a_wb_ack_once: assert property (wbReq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("wishbone ack not a single cycle");

	a_sec_track: assert property (!configLocked && secOverride |=> nonsecureOverride)
		else $error("secure override not applied");

endmodule
`default_nettype wire

// [tcfg_defs.svh]
// Offsets, field positions, reset values and decode constants for the
// tie-off configuration capture block.
// Assumes byte addressing on a 32-bit classic Wishbone register port.
`ifndef TCFG_DEFS_SVH
`define TCFG_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TCFG_ADR_STATUS 8'h00
`define TCFG_ADR_IRQ_LO 8'h04
`define TCFG_ADR_IRQ_HI 8'h08
`define TCFG_ADR_DEVID 8'h0c
`define TCFG_ADR_MATCH 8'h10

// ------------------------------------------------------------
// Status register field positions
// ------------------------------------------------------------
`define TCFG_ST_LOCKED_BIT 0
`define TCFG_ST_COH_BIT 1
`define TCFG_ST_BTM_BIT 2
`define TCFG_ST_SEV_BIT 3
`define TCFG_ST_SEC_BIT 4
`define TCFG_ST_HTTU_BIT 5
`define TCFG_ST_ID0_LSB 6
`define TCFG_ST_OAS_LSB 8
`define TCFG_ST_BITS_LSB 12
`define TCFG_ST_OBS_BIT 20
`define TCFG_ST_REV_LSB 24

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TCFG_RST_WORD 32'h0000_0000
`define TCFG_RST_IRQ_HI 20'h0_0000

// ------------------------------------------------------------
// Output address size codes and decoded widths
// ------------------------------------------------------------
`define TCFG_OAS_32 3'h0
`define TCFG_OAS_36 3'h1
`define TCFG_OAS_40 3'h2
`define TCFG_OAS_42 3'h3
`define TCFG_OAS_44 3'h4
`define TCFG_OAS_48 3'h5
`define TCFG_OAS_52 3'h6
`define TCFG_BITS_32 6'h20
`define TCFG_BITS_36 6'h24
`define TCFG_BITS_40 6'h28
`define TCFG_BITS_42 6'h2a
`define TCFG_BITS_44 6'h2c
`define TCFG_BITS_48 6'h30
`define TCFG_BITS_52 6'h34

// ------------------------------------------------------------
// Table update capability field values
// ------------------------------------------------------------
`define TCFG_ID0_NONE 2'h0
`define TCFG_ID0_ATOMIC 2'h2

`endif

// [tcfg_pkg.sv]
// Types shared by the tie-off configuration capture block.
// Assumes the constants header is included by the design files.
package tcfg_pkg;

	// ------------------------------------------------------------
	// Data types
	// ------------------------------------------------------------
	typedef logic [31:0] tcfg_word_t;
	typedef logic [51:0] tcfg_addr_t;
	typedef logic [127:0] tcfg_obs_word_t;
	typedef logic [3:0] tcfg_qual_t;
	typedef logic [5:0] tcfg_bits_t;

	// ------------------------------------------------------------
	// Capture sequencer states
	// ------------------------------------------------------------
	typedef enum logic [0:0]
	{
		TCFG_SAMPLE = 1'b0,
		TCFG_LOCKED = 1'b1
	} tcfg_state_t;

endpackage

// [tcfg_sync.sv]
// Three-stage synchroniser for an asynchronous level input.
// Assumes the input is a slow level; output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module tcfg_sync
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic asyncIn,
	output logic syncOut
);
	import tcfg_pkg::*;

	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} tcfg_sync_state_t;

	tcfg_sync_state_t st_reg;
	tcfg_sync_state_t st_next;

	// Shift chain; first stage feeds only the second
	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = asyncIn;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3)
		begin
			st_next.out = st_reg.s3;
		end
	end

	// State register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign syncOut = st_reg.out;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_sync_agree: assert property ($changed(syncOut) |-> $past(st_reg.s2) == $past(st_reg.s3))
		else $error("synchroniser output moved without agreement");

endmodule
`default_nettype wire

// [tcfg_partner_model.sv]
// Stand-in for the integration tie-offs and the power-domain controller.
// Assumes the bench hands over a packed configuration and a run request on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module tcfg_partner_model
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic loadCfg,
	input wire logic [95:0] cfgIn,
	input wire logic runReq,
	output logic powerDomainLpiRun,
	output logic supCoherent,
	output logic supBroadcastMaint,
	output logic supSendEvent,
	output logic [2:0] supOutAddrSize,
	output logic secOverride,
	output tcfg_pkg::tcfg_qual_t engRevision,
	output logic supAtomic,
	output tcfg_pkg::tcfg_addr_t msgAddrTie,
	output tcfg_pkg::tcfg_word_t streamIdTie
);
	import tcfg_pkg::*;

	logic [95:0] cfgReg = '0;

	// ------------------------------------------------------------
	// Tie-off holding
	// ------------------------------------------------------------
	// Moves only in reset or after run, never inside the sampling window
	always_ff @(posedge clk_sys)
	begin
		if (loadCfg && (sys_rst || runReq))
		begin
			cfgReg <= cfgIn;
		end
	end

	// Bench picks meaningful values for coherency, broadcast, event and revision
	assign {supCoherent, supBroadcastMaint, supSendEvent} = cfgReg[95:93];
	assign {supOutAddrSize, secOverride, engRevision, supAtomic} = cfgReg[92:84];
	assign {msgAddrTie, streamIdTie} = cfgReg[83:0];

	// Run level is never shown while reset is held
	assign powerDomainLpiRun = runReq & ~sys_rst;
endmodule
`default_nettype wire

// [tb_tcfg_capture.sv]
// Self-checking bench for the tie-off capture block.
// Assumes the partner model stands in for tie-offs and power-domain run level.
`timescale 1ns/1ps
`include "tcfg_defs.svh"
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_tcfg_capture;
	import tcfg_pkg::*;

	localparam int NG = 2;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic loadCfg = 1'b0;
	logic runReq = 1'b0;
	logic analyzerEnable = 1'b0;
	logic [95:0] cfgIn = '0;
	logic [NG*128-1:0] obsWordIn = '0;
	logic [NG*4-1:0] obsQualIn = '0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	tcfg_word_t wb_dat_i = '0, wb_dat_o, msgDeviceId, streamIdTie;
	logic powerDomainLpiRun, supCoherent, supBroadcastMaint, supSendEvent, secOverride, supAtomic;
	logic [2:0] supOutAddrSize;
	tcfg_qual_t engRevision;
	tcfg_addr_t msgAddrTie;
	logic [NG*128-1:0] observation_word;
	logic [NG*4-1:0] observation_qualifier;
	logic [NG-1:0] observation_clk_enable;
	logic configLocked, coherentWalk, broadcastMaintEn, sendEventAvail, nonsecureOverride;
	logic tableUpdateEnable, deliverOnStream, wb_ack_o;
	logic [1:0] id0_table_update_field;
	tcfg_bits_t outputAddrBits;
	logic [NG*128-1:0] obsWordFree;
	logic [NG-1:0] obsEnFree;
	int num_errors = 0;
	int num_checks = 0;

	tcfg_partner_model tcfg_partner_model_i (.clk_sys, .sys_rst, .loadCfg, .cfgIn, .runReq,
		.powerDomainLpiRun, .supCoherent, .supBroadcastMaint, .supSendEvent, .supOutAddrSize,
		.secOverride, .engRevision, .supAtomic, .msgAddrTie, .streamIdTie);

	tcfg_capture #(.NUM_GROUPS(NG), .ANALYZER_BUILD_OPTION(1'b1)) tcfg_capture_i (.clk_sys,
		.sys_rst, .powerDomainLpiRun, .supCoherent, .supBroadcastMaint, .supSendEvent,
		.supOutAddrSize, .secOverride, .engRevision, .msgAddrTie, .streamIdTie, .supAtomic,
		.analyzerEnable, .obsWordIn, .obsQualIn, .observation_word, .observation_qualifier,
		.observation_clk_enable, .configLocked, .coherentWalk, .broadcastMaintEn, .sendEventAvail,
		.nonsecureOverride, .outputAddrBits, .tableUpdateEnable, .id0_table_update_field,
		.msgDeviceId, .deliverOnStream, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);

	// Copy built without the analyzer option; its enable input must have no effect
	tcfg_capture #(.NUM_GROUPS(NG), .ANALYZER_BUILD_OPTION(1'b0)) tcfg_capture_ungated_i (.clk_sys,
		.sys_rst, .powerDomainLpiRun, .supCoherent, .supBroadcastMaint, .supSendEvent,
		.supOutAddrSize, .secOverride, .engRevision, .msgAddrTie, .streamIdTie, .supAtomic,
		.analyzerEnable, .obsWordIn, .obsQualIn, .observation_word(obsWordFree), .observation_qualifier(),
		.observation_clk_enable(obsEnFree), .configLocked(), .coherentWalk(), .broadcastMaintEn(),
		.sendEventAvail(), .nonsecureOverride(), .outputAddrBits(), .tableUpdateEnable(),
		.id0_table_update_field(), .msgDeviceId(), .deliverOnStream(), .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(), .wb_ack_o());

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Clock at 25 MHz
	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end

	function automatic tcfg_bits_t exp_bits(input logic [2:0] c);
		case (c)
			3'h0: return 6'h20;
			3'h1: return 6'h24;
			3'h2: return 6'h28;
			3'h3: return 6'h2a;
			3'h4: return 6'h2c;
			3'h5: return 6'h30;
			default: return 6'h34;
		endcase
	endfunction

	// Status word with the observation gate low and lock set
	function automatic tcfg_word_t exp_status(input logic [95:0] c);
		return {4'h0, c[88:85], 4'h0, 2'h0, exp_bits(c[92:90]), 1'b0, c[92:90],
			c[84], 1'b0, c[84], c[89], c[93], c[94], c[95], 1'b1};
	endfunction

	task automatic close_out;
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Classic single cycle; waits for ack, never assumes its latency
	task automatic wb(input logic we, input logic [7:0] a, input tcfg_word_t d, output tcfg_word_t r);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Only the watchdog ends a wait for ack
		do
		begin
			@(posedge clk_sys);
		end
		while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic chk_cfg(input logic [95:0] c, input logic lk);
		`CHK(configLocked, lk)
		`CHK({coherentWalk, broadcastMaintEn, sendEventAvail}, c[95:93])
		`CHK(outputAddrBits, exp_bits(c[92:90]))
		`CHK(nonsecureOverride, c[89])
		`CHK(tableUpdateEnable, c[84])
		`CHK(id0_table_update_field, c[84] ? 2'b10 : 2'b00)
		`CHK(msgDeviceId, c[31:0])
	endtask

	// ------------------------------------------------------------
	// Watchdog and main sequence
	// ------------------------------------------------------------
	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		close_out();
	end

	initial
	begin
		tcfg_word_t rd;
		logic [95:0] c;
		logic [NG*128-1:0] w;
		void'($urandom(32'hb2beb570));
		// Every size code, the reserved one included
		for (int i = 0; i < 8; i++)
		begin
			c = {$urandom, $urandom, $urandom};
			c[92:90] = i[2:0];
			c[88:85] = 4'h0;
			@(posedge clk_sys);
			sys_rst <= 1'b1;
			runReq <= 1'b0;
			cfgIn <= c;
			loadCfg <= 1'b1;
			repeat (10) @(posedge clk_sys);
			sys_rst <= 1'b0;
			loadCfg <= 1'b0;
			repeat (2) @(posedge clk_sys);
			#1 chk_cfg(c, 1'b0);
			@(posedge clk_sys);
			runReq <= 1'b1;
			@(posedge clk_sys);
			cfgIn <= ~c;
			loadCfg <= 1'b1;
			repeat (3) @(posedge clk_sys);
			loadCfg <= 1'b0;
			#1 chk_cfg(c, 1'b1);
			`CHK(supCoherent, ~c[95])
			// High half first, so the low write completes the match
			wb(1'b1, `TCFG_ADR_IRQ_HI, {12'h0, c[83:64]}, rd);
			wb(1'b1, `TCFG_ADR_IRQ_LO, c[63:32], rd);
			wb(1'b0, `TCFG_ADR_MATCH, '0, rd);
			`CHK(rd[0], 1'b1)
			#1 `CHK(deliverOnStream, 1'b1)
			wb(1'b1, `TCFG_ADR_DEVID, ~c[31:0], rd);
			wb(1'b0, `TCFG_ADR_DEVID, '0, rd);
			`CHK(rd, c[31:0])
			wb(1'b0, `TCFG_ADR_STATUS, '0, rd);
			`CHK(rd, exp_status(c))
			wb(1'b1, `TCFG_ADR_IRQ_LO, c[63:32] ^ (32'h1 << i), rd);
			#1 `CHK(deliverOnStream, 1'b0)
			wb(1'b0, 8'h40, '0, rd);
			`CHK(rd, 32'h0)
		end
		// Observation gate: off, on after synchronising, off again holds
		w = {8{$urandom}};
		@(posedge clk_sys);
		obsWordIn <= w;
		obsQualIn <= 8'h5a;
		repeat (3) @(posedge clk_sys);
		#1 `CHK(observation_clk_enable, 2'b00)
		`CHK(observation_word, {NG*128{1'b0}})
		`CHK(obsEnFree, 2'b11)
		`CHK(obsWordFree, w)
		@(posedge clk_sys);
		analyzerEnable <= 1'b1;
		@(posedge clk_sys);
		#1 `CHK(observation_clk_enable, 2'b00)
		repeat (8) @(posedge clk_sys);
		#1 `CHK(observation_clk_enable, 2'b11)
		`CHK(observation_word, w)
		`CHK(observation_qualifier, 8'h5a)
		@(posedge clk_sys);
		analyzerEnable <= 1'b0;
		repeat (8) @(posedge clk_sys);
		obsWordIn <= ~w;
		repeat (3) @(posedge clk_sys);
		#1 `CHK(observation_word, w)
		`CHK(observation_clk_enable, 2'b00)
		`CHK(obsWordFree, ~w)
		`CHK(obsEnFree, 2'b11)
		close_out();
	end
endmodule
`default_nettype wire
